// ---- fpga_local_bus_port.sv ----
/*
  Interface-side logic of the local-bus port toward the user logic:
  memory select decode, interrupt strobes, boot control registers and
  host access to the user logic registers, all behind an APB slave.
  Assumes all user-logic pins are synchronous to pclk, and that the
  board ties the three-state pins together outside this module.
*/
// Chosen here: the APB slave port.
// How it works
// R01: User logic signals writes by low write levels
// R02: Bank one write target chosen from selects
// R03: Write levels are held levels, not strobes
// R04: RAM write select pulses one clock, later
// R05: Byte enables strobe only selected memory bytes
// R06: Read select held low as chip enable
// R07: Output enable when select low, write high
// R08: Only six select combinations are accepted
// R09: RAM one and flash share enables, never copy
// R10: Three interrupt strobes, inbound ones three cycles
// R11: Strobe width gives interrupt level in bit0
// R12: Either level raises the host IRQ3 request
// R13: Register writes: level low, strobe latches data
// R14: Register reads: select low, user drives data
// R15: Config bytes spread into words by software
// R16: Config converter skips header until all-ones byte
// R17: Sector select then reset pulse reboots logic
// R18: RAM one boot: load, release bus, reset
// R19: Unconfigured: inhibit and reset before loading
// R20: User logic may hold an operation code register
// R21: User address drivers only under bus grant
// R22: User data drivers off during register writes
// R23: Byte enables active low, index zero is MSB
// R24: User logic synchronises incoming strobes
`timescale 1ns/1ns
module fpga_local_bus_port
  import local_bus_port_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [23:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Memory access from the user logic
  input  wire logic        write_level_bank_one_n,
  input  wire logic        write_level_bank_two_n,
  input  wire logic        select_ram_one_n,
  input  wire logic        select_ram_two_n,
  input  wire logic        select_iface_side_n,
  input  wire logic [3:0]  byte_lane_enables_n,
  output logic             ram_one_ce_n,
  output logic             ram_two_ce_n,
  output logic             flash_ce_n,
  output logic             ram_one_oe_n,
  output logic             ram_two_oe_n,
  output logic      [3:0]  ram_one_we_n,
  output logic      [3:0]  ram_two_we_n,
  output logic             flash_we_n,
  // Interrupt strobes
  input  wire logic        dsp_irq_request,
  output logic             host_to_logic_irq_strobe_n,
  output logic             dsp_to_logic_irq_strobe_n,
  input  wire logic        logic_to_host_irq_strobe_n,
  output logic             vme_irq3_n,
  // Host access to user logic registers
  output logic             iface_register_write_level_n,
  output logic             iface_register_strobe_n,
  output logic             iface_register_select_n,
  input  wire logic [18:0] local_addr_lines_in,
  output logic      [18:0] local_addr_lines_out,
  output logic             local_addr_lines_oe,
  input  wire logic [31:0] local_data_lines_in,
  output logic      [31:0] local_data_lines_out,
  output logic             local_data_lines_oe,
  // Boot control toward the configuration logic
  output logic             fpga_reset,
  output logic             boot_from_ram_one,
  output logic      [1:0]  boot_sector,
  output logic             reconfig_start
);

  // ==========================================================
  // Select combination check, active-high {a, b, v}
  function automatic logic valid_combo(input logic [2:0] sel);
    case (sel)
      3'h4, 3'h2, 3'h1, 3'h5, 3'h6, 3'h7: valid_combo = 1'b1;
      default:                            valid_combo = 1'b0;
    endcase
  endfunction

  // ==========================================================
  // Control registers
  logic [31:0] bus_acquire_control;
  logic [31:0] fpga_reset_and_interrupt;
  logic [31:0] boot_source_select;
  logic [31:0] bus_access_inhibit;
  logic        irq_level;
  logic        irq_pending;
  logic        bad_select;
  logic [31:0] mailbox;

  // APB decode
  wire apb_setup   = psel && !penable;
  wire apb_access  = psel && penable;
  wire hit_acq     = (paddr == OFS_BUS_ACQ);
  wire hit_rst     = (paddr == OFS_RESET_IRQ);
  wire hit_boot    = (paddr == OFS_BOOT_SRC);
  wire hit_inh     = (paddr == OFS_INHIBIT);
  wire hit_stat    = (paddr == OFS_STATUS);
  wire hit_mbox    = (paddr == OFS_MAILBOX);
  wire hit_reg     = hit_acq | hit_rst | hit_boot | hit_inh | hit_stat | hit_mbox;
  wire hit_win     = (paddr[23:21] == FPGA_WIN_TAG);
  // The user register bus is only reachable while the host holds bus X
  wire win_ok      = hit_win && bus_acquire_control[BIT_ACQ_X];
  wire reg_wr      = apb_access && pwrite && hit_reg;

  // ==========================================================
  // Memory select decode toward RAMs, flash and interface
  wire enabled  = !bus_access_inhibit[BIT_INHIBIT] && !fpga_reset; // R19
  wire raw_a    = !select_ram_one_n;
  wire raw_b    = !select_ram_two_n;
  wire raw_v    = !select_iface_side_n;
  wire combo_ok = valid_combo({raw_a, raw_b, raw_v}); // R08
  wire act      = combo_ok && enabled;
  // Host-held banks are masked from the user logic
  wire sa       = raw_a && act && !bus_acquire_control[BIT_ACQ_A]; // R18
  wire sb       = raw_b && act && !bus_acquire_control[BIT_ACQ_B];
  wire sv       = raw_v && act;
  wire wr_a     = !write_level_bank_one_n; // R01
  wire wr_b     = !write_level_bank_two_n;
  wire ram_a_en = sa && !sv;                // R02
  wire flash_en = sa && sv;                 // R09
  wire iface_en = sv && !raw_a && !raw_b;

  // Chip enables; select doubles as the write strobe on writes
  assign ram_one_ce_n = !ram_a_en;          // R06
  assign ram_two_ce_n = !sb;
  assign flash_ce_n   = !flash_en;
  // RAM one and flash share one output enable
  assign ram_one_oe_n = !((ram_a_en || flash_en) && !wr_a); // R07 R09
  assign ram_two_oe_n = !(sb && !wr_b);     // R07
  assign flash_we_n   = !(flash_en && wr_a);

  // Per-byte write strobes, index zero is the high byte lane
  for (genvar i = 0; i < 4; i++) begin : g_lane
    assign ram_one_we_n[i] = !(ram_a_en && wr_a && !byte_lane_enables_n[i]); // R05 R23
    assign ram_two_we_n[i] = !(sb && wr_b && !byte_lane_enables_n[i]);       // R05
  end

  // Interface-side write capture fires once per strobe
  logic iface_wr_q;
  wire  iface_wr     = iface_en && wr_a;
  wire  iface_wr_new = iface_wr && !iface_wr_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      iface_wr_q <= 1'b0;
    else
      iface_wr_q <= iface_wr;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      mailbox <= RST_WORD;
    else if (iface_wr_new)
      mailbox <= local_data_lines_in;
  end

  // ==========================================================
  // Inbound interrupt strobes: fixed width, one counter each
  logic [1:0] strobe_fire;
  logic [1:0] strobe_busy;

  assign strobe_fire[0] = reg_wr && hit_rst && pwdata[BIT_HOST_IRQ];
  assign strobe_fire[1] = dsp_irq_request;

  for (genvar g = 0; g < 2; g++) begin : g_strobe
    logic [1:0] cnt;
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
        cnt <= 2'h0;
      else if (strobe_fire[g] && cnt == 2'h0)
        cnt <= 2'(STROBE_CYCLES); // R10
      else if (cnt != 2'h0)
        cnt <= cnt - 2'h1;
    end
    assign strobe_busy[g] = (cnt != 2'h0);
  end

  assign host_to_logic_irq_strobe_n = !strobe_busy[0]; // R10 R20
  assign dsp_to_logic_irq_strobe_n  = !strobe_busy[1]; // R10

  // ==========================================================
  // Outbound interrupt: width sorting and host request
  logic meas_done;
  logic meas_long;

  strobe_width_sorter u_sorter (
    .pclk       (pclk),
    .presetn    (presetn),
    .strobe_n   (logic_to_host_irq_strobe_n),
    .done       (meas_done),
    .long_pulse (meas_long)
  );

  wire stat_clr_pend = reg_wr && hit_stat && pwdata[STAT_PENDING];
  wire stat_clr_bad  = reg_wr && hit_stat && pwdata[STAT_BADSEL];
  wire bad_now       = (raw_a || raw_b || raw_v) && !combo_ok;

  // Sticky flags; a new event outranks a same-cycle clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_pending <= 1'b0;
      irq_level   <= 1'b0;
      bad_select  <= 1'b0;
    end else begin
      irq_pending <= meas_done || (irq_pending && !stat_clr_pend); // R12
      if (meas_done)
        irq_level <= meas_long; // R11
      bad_select  <= bad_now || (bad_select && !stat_clr_bad);    // R08
    end
  end

  assign vme_irq3_n = !irq_pending; // R12

  // ==========================================================
  // Register writes
  logic reset_bit_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus_acquire_control      <= RST_WORD;
      fpga_reset_and_interrupt <= RST_WORD;
      boot_source_select       <= RST_WORD; // R17
      bus_access_inhibit       <= RST_WORD;
    end else if (reg_wr) begin
      if (hit_acq)
        bus_acquire_control <= pwdata;
      if (hit_rst)
        fpga_reset_and_interrupt[BIT_FPGA_RESET] <= pwdata[BIT_FPGA_RESET];
      if (hit_boot)
        boot_source_select <= pwdata;
      if (hit_inh)
        bus_access_inhibit <= pwdata;
    end
  end

  // Reset release starts a reconfiguration from the chosen source
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reset_bit_q    <= 1'b0;
      reconfig_start <= 1'b0;
    end else begin
      reset_bit_q    <= fpga_reset;
      reconfig_start <= reset_bit_q && !fpga_reset; // R17 R18
    end
  end

  assign fpga_reset        = fpga_reset_and_interrupt[BIT_FPGA_RESET]; // R19
  assign boot_from_ram_one = boot_source_select[BIT_BOOT_RAM];         // R18
  assign boot_sector       = boot_source_select[1:0] & SECTOR_W_MASK;  // R17

  // ==========================================================
  // Host access sequencer toward the user logic registers
  xfer_state_e state;
  xfer_state_e next_state;
  logic [1:0]  cnt;
  wire         cnt_end = (cnt == 2'h0);
  wire         start   = apb_setup && win_ok;

  always_comb begin
    next_state = state;
    case (state)
      XF_IDLE:      if (start) next_state = pwrite ? XF_WR_SETUP : XF_RD_WAIT;
      XF_WR_SETUP:  if (cnt_end) next_state = XF_WR_STROBE; // R04
      XF_WR_STROBE: next_state = XF_DONE;
      XF_RD_WAIT:   if (cnt_end) next_state = XF_DONE;
      XF_DONE:      next_state = XF_IDLE;
      default:      next_state = XF_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      state <= XF_IDLE;
    else
      state <= next_state;
  end

  // Wait counter loaded on entry to the setup or read wait
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      cnt <= 2'h0;
    else if (start && state == XF_IDLE)
      cnt <= pwrite ? 2'(WRITE_SETUP_CYCLES - 1) : 2'(READ_WAIT_CYCLES - 1);
    else if (!cnt_end)
      cnt <= cnt - 2'h1;
  end

  // Pin controls registered from the next state
  wire nx_wr = (next_state == XF_WR_SETUP) || (next_state == XF_WR_STROBE);
  wire nx_rd = (next_state == XF_RD_WAIT);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      iface_register_write_level_n <= 1'b1;
      iface_register_strobe_n      <= 1'b1;
      iface_register_select_n      <= 1'b1;
      local_addr_lines_oe          <= 1'b0;
      local_data_lines_oe          <= 1'b0;
    end else begin
      iface_register_write_level_n <= !nx_wr;                      // R13
      iface_register_strobe_n      <= !(next_state == XF_WR_STROBE); // R13
      iface_register_select_n      <= !nx_rd;                      // R14
      local_addr_lines_oe          <= nx_wr || nx_rd;
      local_data_lines_oe          <= nx_wr; // R22
    end
  end

  // Address and data held for the whole access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      local_addr_lines_out <= 19'h0;
      local_data_lines_out <= RST_WORD;
    end else if (start && state == XF_IDLE) begin
      local_addr_lines_out <= paddr[20:2];
      local_data_lines_out <= pwdata;
    end
  end

  // ==========================================================
  // APB read data and answer
  wire [31:0] status_word = {29'h0, bad_select, irq_pending, irq_level};
  wire [31:0] read_mux =
      hit_acq  ? bus_acquire_control :
      hit_rst  ? fpga_reset_and_interrupt :
      hit_boot ? boot_source_select :
      hit_inh  ? bus_access_inhibit :
      hit_stat ? status_word :
      hit_mbox ? mailbox : RST_WORD;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      prdata <= RST_WORD;
    else if (state == XF_RD_WAIT && cnt_end)
      prdata <= local_data_lines_in; // R14
    else if (apb_setup && !hit_win)
      prdata <= read_mux;
  end

  // Window accesses with bus X held wait for the sequencer; others answer at once
  assign pready  = apb_access && (win_ok ? (state == XF_DONE) : 1'b1);
  assign pslverr = apb_access && !hit_reg && !win_ok;

endmodule

// ---- fpga_local_bus_port_chk.sv ----
/*
  Checker for the local-bus port: decode, strobe and register-access timing.
  Assumes binding to fpga_local_bus_port, one clock, async active-low reset.
*/
`timescale 1ns/1ns
module fpga_local_bus_port_chk (
  input wire logic       pclk,
  input wire logic       presetn,
  input wire logic       select_ram_one_n,
  input wire logic       select_ram_two_n,
  input wire logic       select_iface_side_n,
  input wire logic       write_level_bank_one_n,
  input wire logic [3:0] byte_lane_enables_n,
  input wire logic       ram_one_ce_n,
  input wire logic       ram_two_ce_n,
  input wire logic       flash_ce_n,
  input wire logic       ram_one_oe_n,
  input wire logic [3:0] ram_one_we_n,
  input wire logic       host_to_logic_irq_strobe_n,
  input wire logic       dsp_to_logic_irq_strobe_n,
  input wire logic       logic_to_host_irq_strobe_n,
  input wire logic       vme_irq3_n,
  input wire logic       iface_register_write_level_n,
  input wire logic       iface_register_strobe_n,
  input wire logic       iface_register_select_n,
  input wire logic       local_data_lines_oe
);
  // ==========================================================
  // Assertions
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_RAM1_CE: assert property (!ram_one_ce_n |-> !select_ram_one_n && select_iface_side_n)
    else $error("ram one enable without its select");
  AST_FLASH_CE: assert property (!flash_ce_n |-> !select_ram_one_n && !select_iface_side_n)
    else $error("flash enable without both selects");
  AST_RAM2_CE: assert property (!ram_two_ce_n |-> !select_ram_two_n)
    else $error("ram two enable without its select");
  AST_BADSEL: assert property (select_ram_one_n && !select_ram_two_n && !select_iface_side_n
    |-> ram_one_ce_n && ram_two_ce_n && flash_ce_n)
    else $error("invalid select combination enabled a device");
  AST_OE: assert property (!ram_one_oe_n |-> write_level_bank_one_n)
    else $error("output enable during write");
  AST_LANES: assert property (ram_one_we_n != 4'hf
    |-> ((~ram_one_we_n & byte_lane_enables_n) == 4'h0) && !write_level_bank_one_n)
    else $error("write strobe on an unselected lane");
  AST_HOST_STB: assert property ($fell(host_to_logic_irq_strobe_n)
    |-> !host_to_logic_irq_strobe_n [*3] ##1 host_to_logic_irq_strobe_n)
    else $error("host strobe not three cycles");
  AST_DSP_STB: assert property ($fell(dsp_to_logic_irq_strobe_n)
    |-> !dsp_to_logic_irq_strobe_n [*3] ##1 dsp_to_logic_irq_strobe_n)
    else $error("dsp strobe not three cycles");
  AST_IRQ3: assert property ($rose(logic_to_host_irq_strobe_n) |-> ##2 !vme_irq3_n)
    else $error("no bus interrupt request after strobe");
  AST_REG_WR: assert property (!iface_register_strobe_n |-> !iface_register_write_level_n
    && local_data_lines_oe && !$past(iface_register_write_level_n))
    else $error("register strobe outside write level");
  AST_REG_RD: assert property (!iface_register_select_n
    |-> !local_data_lines_oe && iface_register_write_level_n)
    else $error("data driven during register read");
  // Main scenarios reached
  cover property ($fell(vme_irq3_n));
  cover property (!iface_register_strobe_n);
  cover property (!flash_ce_n && !ram_two_ce_n);
endmodule

// ---- fpga_local_bus_port_tb_top.sv ----
/*
  Self-checking bench: APB master, user-logic model, decode and strobe tests.
  Assumes the design package and a 50 ns pclk.
*/
`timescale 1ns/1ns
module fpga_local_bus_port_tb_top;
  import local_bus_port_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [23:0] paddr;
  logic [31:0] pwdata, prdata, local_data_lines_in, local_data_lines_out, rd, seed;
  logic write_level_bank_one_n, write_level_bank_two_n, select_ram_one_n;
  logic select_ram_two_n, select_iface_side_n, ram_one_ce_n, ram_two_ce_n, flash_ce_n;
  logic ram_one_oe_n, ram_two_oe_n, flash_we_n, dsp_irq_request, vme_irq3_n;
  logic host_to_logic_irq_strobe_n, dsp_to_logic_irq_strobe_n, logic_to_host_irq_strobe_n;
  logic iface_register_write_level_n, iface_register_strobe_n, iface_register_select_n;
  logic local_addr_lines_oe, local_data_lines_oe, fpga_reset, boot_from_ram_one;
  logic reconfig_start, err;
  logic [3:0]  byte_lane_enables_n, ram_one_we_n, ram_two_we_n;
  logic [18:0] local_addr_lines_in, local_addr_lines_out;
  logic [1:0]  boot_sector;
  logic [31:0] exp_mem [8];
  logic [7:0]  raw [$];
  int bad_count = 0, checks = 0, i, n;
  // ==========================================================
  // Design, far side and clock
  fpga_local_bus_port uut (.*);
  user_logic_model ulm (.*);
  assign local_addr_lines_in = ~local_addr_lines_out;
  always #25 pclk = ~pclk;
  // ==========================================================
  // Shared tasks
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Configuration byte spread onto a 32-bit word
  function automatic logic [31:0] spread(input logic [7:0] b);
    return {5'h0, b[7], 5'h0, b[6:4], 7'h0, b[3], 5'h0, b[2:0], 2'h0};
  endfunction
  task automatic stop_test;
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      $display("wrong value %s expected %h seen %h", nm, e, g);
      bad_count++;
    end
  endtask
  // One APB transfer; ready, data and error taken at the rising edge, then released
  task automatic apb(input logic w, input logic [23:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    rd = prdata; err = pslverr;
    psel <= 0; penable <= 0;
    if (k >= 20) begin
      bad_count++;
      stop_test;
    end
  endtask
  // Width of the next low pulse on a strobe, bounded
  task automatic width(input bit dsp, output int w);
    int k;
    w = 0;
    for (k = 0; k < 40 && w < 9; k++) begin
      @(negedge pclk);
      if ((dsp ? dsp_to_logic_irq_strobe_n : host_to_logic_irq_strobe_n) === 1'b0)
        w++;
      else if (w > 0)
        break;
    end
  endtask
  task automatic sel(input logic [2:0] c, input logic wl);
    @(posedge pclk);
    {select_ram_one_n, select_ram_two_n, select_iface_side_n} <= ~c;
    write_level_bank_one_n <= wl; write_level_bank_two_n <= wl;
    @(negedge pclk);
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
    {write_level_bank_one_n, write_level_bank_two_n} = 2'h3;
    {select_ram_one_n, select_ram_two_n, select_iface_side_n} = 3'h7;
    byte_lane_enables_n = 4'hf; dsp_irq_request = 0; logic_to_host_irq_strobe_n = 1;
    seed = 32'h5aa1;
    repeat (10) @(posedge pclk);
    presetn <= 1;
    for (i = 0; i < 4; i++) begin
      apb(0, OFS_BUS_ACQ + 24'(4 * i), 0);
      chk("reset word", RST_WORD, rd);
    end
    apb(1, OFS_BOOT_SRC, 32'h10002); apb(0, OFS_BOOT_SRC, 0);
    chk("boot word", 32'h10002, rd);
    chk("sector", 2, boot_sector); chk("ram boot", 1, boot_from_ram_one);
    apb(0, 24'h800018, 0); chk("unmapped", 1, err);
    apb(1, OFS_INHIBIT, 1); sel(3'b100, 1);
    chk("inhibit", 1, ram_one_ce_n);
    sel(3'b000, 1); apb(1, OFS_INHIBIT, 0);
    apb(1, OFS_RESET_IRQ, 1); @(negedge pclk);
    chk("held", 1, fpga_reset);
    apb(1, OFS_RESET_IRQ, 0); n = 0;
    for (i = 0; i < 8; i++) begin
      @(negedge pclk);
      if (reconfig_start === 1'b1) n++;
    end
    chk("reboot", 1, n);
    $display("test boot done");
    apb(1, OFS_RESET_IRQ, 32'h10000); width(0, n); chk("host strobe", 3, n);
    @(posedge pclk); dsp_irq_request <= 1; @(posedge pclk); dsp_irq_request <= 0;
    width(1, n); chk("dsp strobe", 3, n);
    for (i = 0; i < 2; i++) begin
      @(posedge pclk);
      logic_to_host_irq_strobe_n <= 0; repeat (i ? 3 : 1) @(posedge pclk);
      logic_to_host_irq_strobe_n <= 1; repeat (4) @(posedge pclk);
      apb(0, OFS_STATUS, 0); chk("level", i + 2, rd & 3);
      chk("irq3", 0, vme_irq3_n);
      apb(1, OFS_STATUS, 2); @(negedge pclk);
      chk("irq3 clear", 1, vme_irq3_n);
    end
    $display("test interrupts done");
    for (i = 0; i < 8; i++) begin
      sel(3'(i), 1);
      n = (i == 3) ? 0 : i;
      chk("enables", 3'(~{n[2] & !n[0], n[1], n[2] & n[0]}),
          {ram_one_ce_n, ram_two_ce_n, flash_ce_n});
      chk("oe", 2'(~{n[2], n[1]}), {ram_one_oe_n, ram_two_oe_n});
    end
    apb(0, OFS_STATUS, 0); chk("bad select", 1, rd[2]);
    // Byte enables and write level first, select pulsed one clock two clocks later
    for (i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      @(posedge pclk);
      byte_lane_enables_n <= seed[3:0];
      {write_level_bank_one_n, write_level_bank_two_n} <= 2'h0;
      @(posedge pclk);
      sel(3'b110, 0);
      chk("lanes", seed[3:0], ram_one_we_n);
      chk("lanes two", seed[3:0], ram_two_we_n);
      chk("no oe", 1, ram_one_oe_n);
      sel(3'b000, 0);
    end
    sel(3'b101, 0); chk("flash we", 0, flash_we_n);
    sel(3'b000, 1);
    $display("test decode done");
    apb(0, 24'h400000, 0); chk("no bus x", 1, err);
    apb(1, OFS_BUS_ACQ, 32'h10000);
    // Converter: header dropped up to the all-ones byte
    seed = lfsr(seed); raw = {8'h3c, 8'h81, 8'hff, 8'h00, seed[7:0], seed[15:8]};
    while (raw.size() > 0 && raw[0] != 8'hff) void'(raw.pop_front());
    chk("second byte", 0, raw[1]);
    chk("ff word", 32'h041c041c, spread(raw[0]));
    for (i = 0; i < 8; i++) begin
      seed = lfsr(seed); exp_mem[i] = (i < 4) ? seed : spread(raw[i - 4]);
      apb(1, 24'h400000 + 24'(4 * i), exp_mem[i]);
    end
    for (i = 0; i < 8; i++) begin
      apb(0, 24'h400000 + 24'(4 * i), 0);
      chk("user reg", exp_mem[i], rd);
    end
    apb(1, OFS_RESET_IRQ, 32'h10000); width(0, n); chk("op strobe", 3, n);
    $display("test window done");
    stop_test;
  end
endmodule
bind fpga_local_bus_port fpga_local_bus_port_chk chk (.*);

// ---- local_bus_port_pkg.sv ----
/*
  Constants shared by the local-bus port: register byte addresses, field
  positions, reset values and cycle counts.
  Assumes a 24-bit APB byte address and 32-bit APB data.
*/
package local_bus_port_pkg;

  // ==========================================================
  // Register map (byte addresses)
  localparam int          ADDR_W         = 24;
  localparam logic [23:0] OFS_BUS_ACQ    = 24'h800000;
  localparam logic [23:0] OFS_RESET_IRQ  = 24'h800004;
  localparam logic [23:0] OFS_BOOT_SRC   = 24'h800008;
  localparam logic [23:0] OFS_INHIBIT    = 24'h80000c;
  localparam logic [23:0] OFS_STATUS     = 24'h800010;
  localparam logic [23:0] OFS_MAILBOX    = 24'h800014;

  // Window onto the user logic registers: address bits 23:21
  localparam logic [2:0]  FPGA_WIN_TAG   = 3'h2;

  // ==========================================================
  // Field positions
  localparam int BIT_ACQ_A      = 0;
  localparam int BIT_ACQ_B      = 1;
  localparam int BIT_ACQ_X      = 16;
  localparam int BIT_FPGA_RESET = 0;
  localparam int BIT_HOST_IRQ   = 16;
  localparam int BIT_BOOT_RAM   = 16;
  localparam int BIT_INHIBIT    = 0;
  localparam int STAT_LEVEL     = 0;
  localparam int STAT_PENDING   = 1;
  localparam int STAT_BADSEL    = 2;

  // ==========================================================
  // Reset values and masks
  localparam logic [31:0] RST_WORD      = 32'h0000_0000;
  localparam logic [1:0]  SECTOR_W_MASK = 2'h3;

  // ==========================================================
  // Cycle counts
  localparam int STROBE_CYCLES      = 3;
  localparam int WRITE_SETUP_CYCLES = 2;
  localparam int READ_WAIT_CYCLES   = 2;
  localparam int LONG_PULSE_CYCLES  = 2;

  // Transfer sequencer toward the user logic registers
  typedef enum logic [2:0] {
    XF_IDLE,
    XF_WR_SETUP,
    XF_WR_STROBE,
    XF_RD_WAIT,
    XF_DONE
  } xfer_state_e;

endpackage

// ---- strobe_width_sorter.sv ----
/*
  Measures the width of an active-low strobe from the user logic and
  reports, when it ends, whether it was a single-cycle or a longer pulse.
  Assumes the strobe is synchronous to pclk.
*/
`timescale 1ns/1ns
module strobe_width_sorter
  import local_bus_port_pkg::*;
(
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic strobe_n,
  output logic      done,
  output logic      long_pulse
);

  // ==========================================================
  // Width counter, saturates at the long-pulse threshold
  logic [1:0] width;
  logic       was_low;
  wire        ended = was_low && strobe_n;

  // Width counts the low cycles seen so far
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      width   <= 2'h0;
      was_low <= 1'b0;
    end else begin
      was_low <= !strobe_n;
      if (strobe_n)
        width <= 2'h0;
      else if (width != 2'(LONG_PULSE_CYCLES))
        width <= width + 2'h1;
    end
  end

  // Result registered on the release edge of the strobe
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done       <= 1'b0;
      long_pulse <= 1'b0;
    end else begin
      done <= ended;
      if (ended)
        long_pulse <= (width >= 2'(LONG_PULSE_CYCLES)); // R11
    end
  end

endmodule

// ---- user_logic_model.sv ----
/*
  Register file of the user logic as seen over the local bus.
  Assumes the port drives address, data and controls synchronous to pclk.
*/
`timescale 1ns/1ns
module user_logic_model (
  input  wire logic        pclk,
  input  wire logic        iface_register_write_level_n,
  input  wire logic        iface_register_strobe_n,
  input  wire logic        iface_register_select_n,
  input  wire logic [18:0] local_addr_lines_out,
  input  wire logic [31:0] local_data_lines_out,
  output logic      [31:0] local_data_lines_in
);
  logic [31:0] mem [16];
  logic [31:0] last = 32'h0;
  logic        prev = 1'b1;
  wire         drive = !iface_register_select_n && iface_register_write_level_n;
  // Latch on strobe leading edge, seen through a sampled copy
  always @(posedge pclk) begin
    prev <= iface_register_strobe_n;
    if (prev && !iface_register_strobe_n && !iface_register_write_level_n)
      mem[local_addr_lines_out[3:0]] <= local_data_lines_out;
    if (drive)
      last <= mem[local_addr_lines_out[3:0]];
  end
  // Released bus shows inverted last word, never a stale match
  assign local_data_lines_in = drive ? mem[local_addr_lines_out[3:0]] : ~last;
endmodule
